// >>> include/jlp_pkg.sv
// Shared constants and types for the link parameter and alignment block
package jlp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses) and reset values
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned MODE_W     = 5;
    localparam logic [7:0]  OFS_MODE   = 8'h00;
    localparam logic [7:0]  OFS_KM1    = 8'h04;
    localparam logic [7:0]  OFS_DID    = 8'h08;
    localparam logic [7:0]  OFS_CTRL   = 8'h0c;
    localparam logic [7:0]  OFS_MUX    = 8'h10;
    localparam logic [7:0]  OFS_STATUS = 8'h14;
    localparam logic [7:0]  OFS_PARAM0 = 8'h18;
    localparam logic [7:0]  OFS_PARAM1 = 8'h1c;
    localparam logic [4:0]  MODE_RST   = 5'h00;
    localparam logic [7:0]  KM1_RST    = 8'h1f;
    localparam logic [7:0]  DID_RST    = 8'h00;
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_SCR_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Analog input mux settings
    localparam logic [1:0] MUX_INA  = 2'h0;
    localparam logic [1:0] MUX_INB  = 2'h1;
    localparam logic [1:0] MUX_BOTH = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Alignment sequence layout
    localparam int unsigned ILAS_LEN    = 14;
    localparam int unsigned NUM_FIELDS  = 21;
    localparam logic [3:0]  OCT_LAST    = 4'hd;
    localparam logic [2:0]  JESDV_VAL   = 3'h1;
    localparam logic [2:0]  SUBCLV_VAL  = 3'h1;
    localparam logic [5:0]  R_X8_UNITY  = 6'h08;
    localparam logic [1:0]  RATE_DOUBLE = 2'h2;
    localparam logic [1:0]  RATE_SINGLE = 2'h1;

    // Parameters of one link mode; r_x8 is bits per lane per clock times 8
    typedef struct packed {
        logic       valid;
        logic       enc66;
        logic       des;
        logic [4:0] n;
        logic [1:0] cs;
        logic [4:0] np;
        logic [4:0] l;
        logic [7:0] m;
        logic [7:0] f;
        logic [4:0] s;
        logic       hd;
        logic [5:0] r_x8;
    } jlp_mode_s;

    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_CGS  = 4'b0010,
        ST_ILAS = 4'b0100,
        ST_DATA = 4'b1000
    } jlp_state_e;

endpackage : jlp_pkg

// >>> logic/jlp_mode_table.sv
// Link mode decode: derives transport and rate parameters from the mode
`timescale 1ns/1ps
`default_nettype none
module jlp_mode_table
    import jlp_pkg::*;
(
    input  wire logic [jlp_pkg::MODE_W-1:0] mode,
    output jlp_pkg::jlp_mode_s              prm
);

    // One table row; all printed modes use 8b/10b
    function automatic jlp_mode_s row(input logic d, input logic [4:0] n, input logic [1:0] cs,
                                      input logic [4:0] np, input logic [4:0] l,
                                      input logic [7:0] m, input logic [7:0] f,
                                      input logic [4:0] s, input logic hd,
                                      input logic [5:0] r);
        jlp_mode_s v;
        v = '{valid: 1'b1, enc66: 1'b0, des: d, n: n, cs: cs, np: np, l: l, m: m, f: f,
              s: s, hd: hd, r_x8: r};
        return v;
    endfunction : row

    // Reserved codes decode as invalid and keep the link idle
    always_comb
    begin
        prm = '0;
        case (mode)
            5'h00: prm = row(1'b1, 5'h0c, 2'h0, 5'h0c, 5'h04, 8'h04, 8'h08, 5'h05, 1'b0, 6'h20);
            5'h01: prm = row(1'b1, 5'h0c, 2'h0, 5'h0c, 5'h08, 8'h08, 8'h08, 5'h05, 1'b0, 6'h10);
            5'h02: prm = row(1'b0, 5'h0c, 2'h0, 5'h0c, 5'h04, 8'h04, 8'h08, 5'h05, 1'b0, 6'h20);
            5'h03: prm = row(1'b0, 5'h0c, 2'h0, 5'h0c, 5'h08, 8'h08, 8'h08, 5'h05, 1'b0, 6'h10);
            5'h05: prm = row(1'b1, 5'h08, 2'h0, 5'h08, 5'h04, 8'h01, 8'h01, 5'h04, 1'b0, 6'h14);
            5'h06: prm = row(1'b1, 5'h08, 2'h0, 5'h08, 5'h08, 8'h01, 8'h01, 5'h08, 1'b0, 6'h0a);
            5'h07: prm = row(1'b0, 5'h08, 2'h0, 5'h08, 5'h04, 8'h01, 8'h01, 5'h04, 1'b0, 6'h14);
            5'h08: prm = row(1'b0, 5'h08, 2'h0, 5'h08, 5'h08, 8'h01, 8'h01, 5'h08, 1'b0, 6'h0a);
            5'h0a: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h02, 8'h02, 8'h02, 5'h01, 1'b0, 6'h28);
            5'h0b: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h04, 8'h02, 8'h02, 5'h02, 1'b0, 6'h14);
            5'h0c: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h08, 8'h02, 8'h02, 5'h04, 1'b0, 6'h0a);
            5'h0d: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h01, 8'h02, 8'h04, 5'h01, 1'b0, 6'h28);
            5'h0e: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h02, 8'h02, 8'h02, 5'h01, 1'b0, 6'h14);
            5'h0f: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h04, 8'h02, 8'h02, 5'h02, 1'b0, 6'h0a);
            5'h10: prm = row(1'b0, 5'h0f, 2'h1, 5'h10, 5'h08, 8'h02, 8'h02, 5'h04, 1'b0, 6'h05);
            5'h13: prm = row(1'b1, 5'h0c, 2'h0, 5'h0c, 5'h06, 8'h01, 8'h02, 5'h08, 1'b1, 6'h14);
            5'h14: prm = row(1'b0, 5'h0c, 2'h0, 5'h0c, 5'h06, 8'h01, 8'h02, 5'h08, 1'b1, 6'h14);
            5'h15: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h02, 8'h01, 8'h02, 5'h02, 1'b0, 6'h28);
            5'h16: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h04, 8'h01, 8'h02, 5'h04, 1'b0, 6'h14);
            5'h17: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h01, 8'h01, 8'h02, 5'h01, 1'b0, 6'h28);
            5'h18: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h02, 8'h01, 8'h02, 5'h02, 1'b0, 6'h14);
            5'h19: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h08, 8'h01, 8'h02, 5'h08, 1'b0, 6'h0a);
            5'h1a: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h04, 8'h01, 8'h02, 5'h04, 1'b0, 6'h0a);
            5'h1b: prm = row(1'b1, 5'h0f, 2'h1, 5'h10, 5'h08, 8'h01, 8'h02, 5'h08, 1'b0, 6'h05);
            default: prm = '0;
        endcase
    end

endmodule : jlp_mode_table
`default_nettype wire

// >>> logic/jlp_ilas_sum.sv
// Modulo-256 sum of the alignment sequence parameter fields
`timescale 1ns/1ps
`default_nettype none
module jlp_ilas_sum #(
    parameter int unsigned NFIELDS = 21
) (
    input  wire logic [NFIELDS*8-1:0] fields,
    output logic      [7:0]           sum
);

    initial
    begin
        if (NFIELDS < 1)
            $error("jlp_ilas_sum needs at least one field");
    end

    // Carries above bit 7 are dropped, which is the modulo
    always_comb
    begin
        sum = 8'h00;
        for (int i = 0; i < NFIELDS; i++)
            sum = sum + fields[i*8 +: 8];
    end

endmodule : jlp_ilas_sum
`default_nettype wire

// >>> logic/jlp_link_param_ilas.sv
// Link parameter derivation, input interleave control and alignment sequence source
//
// Overview of operation
// - Dual-input interleave samples both channels out of phase; effective rate doubles.
// - Dual-input interleave: single-channel mode with input mux set to both inputs.
// - Dual-input interleave keeps digital path and link as plain single-channel.
// - Link mode register picks channel count and derives all other link parameters except frames per multiframe, scrambling and device id.
// - Interleave flag is one for single-channel modes, zero for dual-channel.
// - Lane carries R bits per clock; R sets serializer multiplier or bypass.
// - Frames per multiframe come from register; used in 8b/10b, ignored in 64b/66b.
// - Multiblocks per extended multiblock fixed at one, only meaningful in 64b/66b.
// - 8b/10b sends all transport fields in alignment sequence; 64b/66b sends none.
// - Adjust count, direction, bank, control words, density, reserved fields send zero.
// - Control bits per sample field always sent as zero.
// - Device identifier field comes from its software register.
// - Standard revision and subclass version fields are always one.
// - Scrambler field mirrors the scrambler enable control bit.
// - Checksum is the sum of all other fields modulo 256.
// - Frames per multiframe field comes from the multiframe length register.
// - Octets, lanes, converters, resolution, sample sizes, lane id are derived.
// - Converter count describes lane packing, may differ from real channel count.
// - Low sync request starts code group sync, then alignment sequence, any subclass.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module jlp_link_param_ilas
    import jlp_pkg::*;
#(
    parameter int unsigned LANE_W = 5
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic [jlp_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [jlp_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [jlp_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        sync_n,
    input  wire logic [LANE_W-1:0]           lane_sel,
    output logic                             des_q,
    output logic                             dual_input_q,
    output logic                             ch_a_input_q,
    output logic                             ch_b_input_q,
    output logic                             ch_b_phase_inv_q,
    output logic      [1:0]                  rate_mult_q,
    output logic      [5:0]                  serdes_mult_q,
    output logic                             serdes_pll_bypass_q,
    output logic      [8:0]                  k_frames_q,
    output logic                             e_mblocks_q,
    output logic                             scr_en_q,
    output logic      [3:0]                  link_state_q,
    output logic                             cgs_active_q,
    output logic                             ilas_valid_q,
    output logic      [3:0]                  ilas_index_q,
    output logic      [7:0]                  ilas_octet_q
);

    initial
    begin
        if (LANE_W < 1 || LANE_W > 5)
            $error("LANE_W must lie between 1 and 5");
    end

    // Count-type fields travel as value minus one
    function automatic logic [7:0] minus1(input logic [7:0] v);
        return v - 8'h01;
    endfunction : minus1

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic       [MODE_W-1:0] mode_q;
    logic       [7:0]        km1_q;
    logic       [7:0]        did_q;
    logic                    link_en_q;
    logic                    scr_q;
    logic       [1:0]        mux_q;
    jlp_mode_s               tbl;
    jlp_mode_s               act_q;
    jlp_state_e              state_q;
    jlp_state_e              state_d;
    logic       [3:0]        idx_q;
    logic       [3:0]        idx_d;
    logic       [7:0]        f_l;
    logic       [7:0]        f_f;
    logic       [7:0]        f_m;
    logic       [7:0]        f_n;
    logic       [7:0]        f_np;
    logic       [7:0]        f_s;
    logic       [7:0]        f_lid;
    logic       [NUM_FIELDS*8-1:0] fields;
    logic       [7:0]        chksum;
    logic       [7:0]        octet_d;
    logic                    dual_in_d;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    jlp_mode_table u_table (
        .mode (mode_q),
        .prm  (tbl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    // Writes land in one cycle; nothing stalls the master
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            mode_q    <= MODE_RST;
            km1_q     <= KM1_RST;
            did_q     <= DID_RST;
            link_en_q <= 1'b0;
            scr_q     <= 1'b0;
            mux_q     <= MUX_INA;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFS_MODE: mode_q    <= reg_wdata[MODE_W-1:0];
                OFS_KM1:  km1_q     <= reg_wdata[7:0];
                OFS_DID:  did_q     <= reg_wdata[7:0];
                OFS_CTRL:
                begin
                    link_en_q <= reg_wdata[CTRL_EN_BIT];
                    scr_q     <= reg_wdata[CTRL_SCR_BIT];
                end
                OFS_MUX:  mux_q     <= reg_wdata[1:0];
                default:  ;
            endcase
        end
    end

    // Read data stand one cycle after the strobe and read zero otherwise
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                OFS_MODE:   reg_rdata <= {27'h0, mode_q};
                OFS_KM1:    reg_rdata <= {24'h0, km1_q};
                OFS_DID:    reg_rdata <= {24'h0, did_q};
                OFS_CTRL:   reg_rdata <= {30'h0, scr_q, link_en_q};
                OFS_MUX:    reg_rdata <= {30'h0, mux_q};
                OFS_STATUS: reg_rdata <= {16'h0, chksum, state_q, act_q.enc66,
                                          dual_input_q, act_q.des, tbl.valid};
                OFS_PARAM0: reg_rdata <= {3'h0, act_q.s, act_q.f, act_q.m, 3'h0, act_q.l};
                OFS_PARAM1: reg_rdata <= {10'h0, act_q.r_x8, act_q.np, act_q.n,
                                          3'h0, act_q.cs, act_q.hd};
                default:    reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Active parameter set
    // Taken only while the link is down so a live link never sees a torn set
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            act_q <= '0;
        else if (state_q == ST_OFF)
            act_q <= tbl;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampling and input control
    // Both inputs only count as interleaved when the mode is single-channel
    assign dual_in_d = act_q.des && (mux_q == MUX_BOTH);

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            des_q            <= 1'b0;
            dual_input_q     <= 1'b0;
            ch_a_input_q     <= 1'b0;
            ch_b_input_q     <= 1'b1;
            ch_b_phase_inv_q <= 1'b0;
            rate_mult_q      <= RATE_SINGLE;
        end
        else
        begin
            des_q            <= act_q.des;
            dual_input_q     <= dual_in_d;
            // Channel A reads INB only when a plain single-input mode picks INB
            ch_a_input_q     <= act_q.des && (mux_q == MUX_INB);
            // Channel B follows A unless dual-channel or both inputs are used
            ch_b_input_q     <= (!act_q.des || dual_in_d) ? 1'b1 : (mux_q == MUX_INB);
            ch_b_phase_inv_q <= act_q.des;
            rate_mult_q      <= act_q.des ? RATE_DOUBLE : RATE_SINGLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate and framing outputs
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            serdes_mult_q       <= '0;
            serdes_pll_bypass_q <= 1'b0;
            k_frames_q          <= '0;
            e_mblocks_q         <= 1'b0;
            scr_en_q            <= 1'b0;
        end
        else
        begin
            serdes_mult_q       <= act_q.r_x8;
            serdes_pll_bypass_q <= (act_q.r_x8 == R_X8_UNITY);
            // Frame count has no meaning under 64b/66b, so it reads zero there
            k_frames_q          <= act_q.enc66 ? 9'h000 : ({1'b0, km1_q} + 9'h001);
            e_mblocks_q         <= act_q.enc66;
            scr_en_q            <= scr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alignment sequence fields
    // Table converter count goes out as is, whatever channels really sample
    assign f_l   = minus1({3'h0, act_q.l});
    assign f_f   = minus1(act_q.f);
    assign f_m   = minus1(act_q.m);
    assign f_n   = minus1({3'h0, act_q.n});
    assign f_np  = minus1({3'h0, act_q.np});
    assign f_s   = minus1({3'h0, act_q.s});
    assign f_lid = {{(8-LANE_W){1'b0}}, lane_sel};

    // Field order is irrelevant to the sum; zero fields kept for completeness
    assign fields = {did_q,
                     8'h00, 8'h00,          // adjust count, bank id
                     8'h00, 8'h00,          // adjust direction, phase adjust
                     f_lid,
                     {7'h0, scr_q},
                     f_l, f_f,
                     km1_q,
                     f_m,
                     8'h00,
                     f_n,
                     {5'h0, SUBCLV_VAL},
                     f_np,
                     {5'h0, JESDV_VAL},
                     f_s,
                     8'h00, 8'h00,          // high density, control words
                     8'h00, 8'h00};         // reserved pair

    jlp_ilas_sum #(
        .NFIELDS (NUM_FIELDS)
    ) u_sum (
        .fields (fields),
        .sum    (chksum)
    );

    // Octet slots; the frame count uses a full octet for counts above 32
    always_comb
    begin
        octet_d = 8'h00;
        case (idx_q)
            4'h0: octet_d = did_q;
            4'h1: octet_d = 8'h00;
            4'h2: octet_d = {3'h0, f_lid[4:0]};
            4'h3: octet_d = {scr_q, 2'h0, f_l[4:0]};
            4'h4: octet_d = f_f;
            4'h5: octet_d = km1_q;
            4'h6: octet_d = f_m;
            4'h7: octet_d = {2'h0, 1'b0, f_n[4:0]};
            4'h8: octet_d = {SUBCLV_VAL, f_np[4:0]};
            4'h9: octet_d = {JESDV_VAL, f_s[4:0]};
            4'ha: octet_d = 8'h00;
            4'hb: octet_d = 8'h00;
            4'hc: octet_d = 8'h00;
            4'hd: octet_d = chksum;
            default: octet_d = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Link start sequence
    always_comb
    begin
        state_d = state_q;
        idx_d   = idx_q;
        case (state_q)
            ST_OFF:
            begin
                idx_d = 4'h0;
                if (link_en_q && tbl.valid)
                    state_d = tbl.enc66 ? ST_DATA : ST_CGS;
            end
            ST_CGS:
            begin
                idx_d = 4'h0;
                if (sync_n)
                    state_d = ST_ILAS;
            end
            ST_ILAS:
            begin
                if (!sync_n)
                    state_d = ST_CGS;
                else if (idx_q == OCT_LAST)
                    state_d = ST_DATA;
                else
                    idx_d = idx_q + 4'h1;
            end
            ST_DATA:
            begin
                // A fresh request restarts sync; 64b/66b has no such request
                if (!act_q.enc66 && !sync_n)
                    state_d = ST_CGS;
            end
            default: state_d = ST_OFF;
        endcase
        if (!link_en_q)
            state_d = ST_OFF;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_OFF;
            idx_q   <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            idx_q   <= idx_d;
        end
    end

    // Stream outputs lag the state by one edge
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            link_state_q <= ST_OFF;
            cgs_active_q <= 1'b0;
            ilas_valid_q <= 1'b0;
            ilas_index_q <= 4'h0;
            ilas_octet_q <= 8'h00;
        end
        else
        begin
            link_state_q <= state_q;
            cgs_active_q <= (state_q == ST_CGS);
            ilas_valid_q <= (state_q == ST_ILAS) && sync_n;
            ilas_index_q <= idx_q;
            ilas_octet_q <= (state_q == ST_ILAS) ? octet_d : 8'h00;
        end
    end

endmodule : jlp_link_param_ilas
`default_nettype wire

// >>> tb/jlp_sva.sv
// Checker of alignment octets, derived flags and read timing
`timescale 1ns/1ps
`default_nettype none
module jlp_sva (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        des_q,
    input wire logic        dual_input_q,
    input wire logic [1:0]  rate_mult_q,
    input wire logic [5:0]  serdes_mult_q,
    input wire logic        serdes_pll_bypass_q,
    input wire logic        cgs_active_q,
    input wire logic        ilas_valid_q,
    input wire logic [3:0]  ilas_index_q,
    input wire logic [7:0]  ilas_octet_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Steps of one alignment pass
    sequence s_cgs_exit; cgs_active_q ##1 ilas_valid_q; endsequence
    sequence s_slot(logic [3:0] k); ilas_valid_q && ilas_index_q == k; endsequence
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_des_dual: assert property (dual_input_q |-> des_q)
        else $error("dual input without single channel");
    chk_rate_des: assert property (rate_mult_q == (des_q ? 2'h2 : 2'h1))
        else $error("rate does not follow interleave");
    chk_pll_bypass: assert property (serdes_pll_bypass_q == (serdes_mult_q == 6'h08))
        else $error("pll bypass wrong");
    chk_ilas_first: assert property (s_cgs_exit |-> ilas_index_q == 4'h0)
        else $error("alignment pass not from octet 0");
    chk_ilas_step: assert property (ilas_valid_q && ilas_index_q < 4'hd |=>
        ilas_valid_q && ilas_index_q == $past(ilas_index_q) + 4'h1)
        else $error("alignment octets not consecutive");
    chk_ilas_len: assert property (s_slot(4'hd) |=> !ilas_valid_q)
        else $error("alignment pass too long");
    chk_zero_slots: assert property (ilas_valid_q && ilas_index_q inside {4'h1, [4'ha:4'hc]}
        |-> ilas_octet_q == 8'h0)
        else $error("fixed zero octet not zero");
    chk_version_one: assert property (ilas_valid_q && ilas_index_q inside {4'h8, 4'h9}
        |-> ilas_octet_q[7:5] == 3'h1)
        else $error("version field not one");
    chk_cs_zero: assert property (s_slot(4'h7) |-> ilas_octet_q[7:5] == 3'h0)
        else $error("control bits field not zero");
endmodule : jlp_sva
bind jlp_link_param_ilas jlp_sva i_jlp_sva (.sys_clk, .reset_n, .reg_rd, .reg_rdata, .des_q,
    .dual_input_q, .rate_mult_q, .serdes_mult_q, .serdes_pll_bypass_q, .cgs_active_q,
    .ilas_valid_q, .ilas_index_q, .ilas_octet_q);
`default_nettype wire

// >>> tb/jlp_rx_model.sv
// Link receiver model: drives the sync request
`timescale 1ns/1ps
`default_nettype none
module jlp_rx_model (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic cgs_active_q,
    input  wire logic slow,
    input  wire logic resync,
    output logic      sync_n
);
    logic [4:0] cnt_q;
    // Low on start or resync; released after a few sync cycles, later when slow
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || resync)
        begin
            sync_n <= 1'b0;
            cnt_q  <= 5'h0;
        end
        else if (cgs_active_q)
        begin
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == (slow ? 5'h13 : 5'h03)) sync_n <= 1'b1;
        end
    end
endmodule : jlp_rx_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the link parameter and alignment block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import jlp_pkg::*;
    logic        sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, resync = 0, slow = 0, rd_d = 0;
    logic        sync_n, des_q, dual_input_q, ch_a_input_q, ch_b_input_q, ch_b_phase_inv_q;
    logic        serdes_pll_bypass_q, e_mblocks_q, scr_en_q, cgs_active_q, ilas_valid_q;
    logic [1:0]  rate_mult_q;
    logic [3:0]  link_state_q, ilas_index_q;
    logic [4:0]  lane_sel = 0;
    logic [5:0]  serdes_mult_q;
    logic [7:0]  reg_addr = 0, ilas_octet_q, md, l, f, m, n, np, s, r8, d, km1, did, scr, iq[$];
    logic [8:0]  k_frames_q;
    logic [31:0] reg_wdata = 0, reg_rdata, seed = 32'd52, rq[$];
    // Mode, L-1, F-1, M-1, N-1, N'-1, S-1, R*8, single channel
    logic [71:0] tbl[3] = '{72'h00_03_07_03_0b_0b_04_20_01, 72'h0a_01_01_01_0e_0f_00_28_00,
                            72'h13_05_01_00_0b_0b_07_14_01};
    int          errors = 0, check_count = 0;
    jlp_link_param_ilas i_jlp_link_param_ilas (.*);
    jlp_rx_model i_jlp_rx_model (.*);
    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog, about forty times the expected run
    always #10 sys_clk = ~sys_clk;
    initial begin #200000; errors++; end_of_test(); end
    always @(posedge sys_clk) rd_d <= reg_rd;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    // One bus cycle; a read notes its expected answer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= v;
        if (!w) rq.push_back(v);
        @(posedge sys_clk);
    endtask : bus
    task automatic idle(input int c);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (c) @(posedge sys_clk);
    endtask : idle
    task automatic kick();
        resync <= 1'b1;
        @(posedge sys_clk);
        resync <= 1'b0;
    endtask : kick
    // Bounded wait, sampled off the edge
    task automatic wait_st(input logic [3:0] st);
        @(negedge sys_clk);
        for (int i = 0; i < 300 && link_state_q !== st; i++) @(negedge sys_clk);
        chk(link_state_q === st, "link state");
        @(posedge sys_clk);
    endtask : wait_st
    // Checksum sums field values, so flag and versions count as one
    task automatic push_ilas();
        logic [7:0] o[14];
        o = '{did, 8'h0, {3'h0, lane_sel}, {scr[0], 2'h0, l[4:0]}, f, km1, m, {3'h0, n[4:0]},
              {3'h1, np[4:0]}, {3'h1, s[4:0]}, 8'h0, 8'h0, 8'h0, 8'h0};
        o[13] = did + lane_sel + scr + l + f + km1 + m + n + 8'h1 + np + 8'h1 + s;
        foreach (o[i]) iq.push_back(o[i]);
    endtask : push_ilas
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    // Result side: oldest note against what appears
    always @(negedge sys_clk)
    begin
        if (rd_d)
        begin
            chk(rq.size() > 0 && reg_rdata === rq[0], "read data");
            if (rq.size() > 0) void'(rq.pop_front());
        end
        if (ilas_valid_q === 1'b1)
        begin
            chk(iq.size() > 0 && ilas_octet_q === iq[0], "octet");
            if (iq.size() > 0) void'(iq.pop_front());
        end
    end
    // Stimulus: three modes with random identity, length and lane, then a reserved mode
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        bus(0, OFS_KM1, {24'h0, KM1_RST});
        bus(0, 8'h20, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            {md, l, f, m, n, np, s, r8, d} = tbl[i];
            seed = rnd();
            did = seed[7:0];
            km1 = {seed[11:8] | 4'h1, 4'hf};
            scr = {7'h0, seed[12]};
            lane_sel <= seed[20:16];
            slow <= i[0];
            bus(1, OFS_MODE, {24'h0, md});
            bus(1, OFS_KM1, {24'h0, km1});
            bus(1, OFS_DID, {24'h0, did});
            bus(1, OFS_MUX, 32'h2);
            bus(0, OFS_DID, {24'h0, did});
            idle(1);
            kick();
            push_ilas();
            bus(1, OFS_CTRL, {30'h0, scr[0], 1'b1});
            idle(1);
            wait_st(4'h8);
            chk(des_q === d[0] && dual_input_q === d[0], "interleave");
            chk(rate_mult_q === (d[0] ? 2'h2 : 2'h1) && ch_b_phase_inv_q === d[0], "rate");
            chk(ch_a_input_q === 1'b0 && ch_b_input_q === 1'b1, "input mux");
            chk(serdes_mult_q === r8[5:0] && k_frames_q === km1 + 9'h1, "lane rate");
            chk(scr_en_q === scr[0] && e_mblocks_q === 1'b0, "scrambler");
            push_ilas();
            kick();
            wait_st(4'h2);
            wait_st(4'h8);
            bus(1, OFS_CTRL, 32'h0);
            idle(3);
            chk(iq.size() == 0, "octet count");
            $display("mode %0d done", md);
        end
        bus(1, OFS_MODE, 32'h4);
        bus(1, OFS_CTRL, 32'h1);
        idle(6);
        wait_st(4'h1);
        $display("reserved mode done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
